// >>> inc/exec_pkg.sv
// Constants, register map and state encoding for the instruction execution
// block. Assumes a 50 MHz clock and an AXI4-Lite master with 32-bit data.
package exec_pkg;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_INSTR = 8'h04;
    localparam logic [7:0] REG_WREG = 8'h08;
    localparam logic [7:0] REG_BSR = 8'h0c;
    localparam logic [7:0] REG_PC = 8'h10;
    localparam logic [7:0] REG_PC_HIGH_LATCH = 8'h14;
    localparam logic [7:0] REG_PC_UPPER_LATCH = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam logic [7:0] REG_TOS = 8'h20;
    localparam logic [7:0] REG_WDT = 8'h24;
    localparam logic [7:0] REG_FSR2 = 8'h28;
    localparam logic [7:0] REG_MEM_ADDR = 8'h2c;
    localparam logic [7:0] REG_MEM_DATA = 8'h30;

    localparam int CTRL_GO = 0;
    localparam int CTRL_EXT = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_N = 1;
    localparam int ST_Z = 2;
    localparam int ST_TO = 3;
    localparam int ST_PD = 4;
    localparam int ST_BAD = 5;
    localparam int ST_OVF = 6;
    localparam int TOS_SP_LSB = 24;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam logic [15:0] OP_CALL_W = 16'h0014;
    localparam logic [15:0] OP_CLR_WDT = 16'h0004;
    localparam logic [6:0] OP_CLEAR_FILE_REG_HI = 7'h35;
    localparam logic [5:0] OP_COMPLEMENT_FILE_REG_HI = 6'h07;
    localparam logic [7:0] ILO_LIMIT = 8'h5f;

    localparam logic [1:0] Q_DECODE = 2'h0;
    localparam logic [1:0] Q_READ = 2'h1;
    localparam logic [1:0] Q_PROC = 2'h2;
    localparam logic [1:0] Q_WRITE = 2'h3;
    localparam logic [20:0] PC_STEP = 21'h000002;

    localparam logic TO_RST = 1'b1;
    localparam logic PD_RST = 1'b1;

    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_NOP} exec_state_type;
endpackage

// >>> src/watchdog_counter.sv
// Watchdog counter with postscaler, cleared by the execution block.
// Assumes clk, srst and ce are shared with the instantiating block.
`timescale 1ns/1ps
module watchdog_counter
    import exec_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int POST_W = 4
)(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic clr,
    output logic [CNT_W-1:0] count,
    output logic [POST_W-1:0] post,
    output logic timeout
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic [POST_W-1:0] post;
        logic timeout;
    } wdt_state_type;

    wdt_state_type wdt_ff;
    wdt_state_type nxt_wdt;

    always_comb
    begin
        nxt_wdt = wdt_ff;
        nxt_wdt.timeout = 1'b0;
        if (clr)
        begin
            nxt_wdt.count = '0;
            nxt_wdt.post = '0;
        end
        else
        begin
            nxt_wdt.count = wdt_ff.count + 1'b1;
            if (&wdt_ff.count)
            begin
                nxt_wdt.post = wdt_ff.post + 1'b1;
                // Expiry wraps and keeps running; timeout pulses high for one enabled cycle
                nxt_wdt.timeout = &wdt_ff.post;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            wdt_ff <= '0;
        else if (ce)
            wdt_ff <= nxt_wdt;
    end

    assign count = wdt_ff.count;
    assign post = wdt_ff.post;
    assign timeout = wdt_ff.timeout;
endmodule

// >>> src/call_clear_complement_exec.sv
// Executes accumulator call, clear-register, clear-watchdog and complement.
// Assumes an AXI4-Lite master on clk; one quarter cycle per enabled clock.
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module call_clear_complement_exec
    import exec_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int STACK_DEPTH = 31,
    parameter int WDT_CNT_W = 8,
    parameter int WDT_POST_W = 4
)(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int SP_W = $clog2(STACK_DEPTH + 1);
    localparam int BSR_W = ADDR_W - 8;

    typedef struct packed {
        exec_state_type st;
        logic [1:0] q;
        logic [15:0] ir;
        logic ext;
        logic [7:0] wreg;
        logic [BSR_W-1:0] bank_select_reg;
        logic [20:0] pc;
        logic [7:0] pc_high_latch;
        logic [4:0] pc_upper_latch;
        logic [SP_W-1:0] sp;
        logic [ADDR_W-1:0] ea;
        logic [ADDR_W-1:0] fsr2;
        logic [ADDR_W-1:0] mem_addr;
        logic [7:0] opnd;
        logic [7:0] res;
        logic n;
        logic z;
        logic to_flag;
        logic pd_flag;
        logic bad;
        logic ovf;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } state_type;

    state_type state_ff;
    state_type nxt_state;
    logic [7:0] mem [2**ADDR_W];
    logic [20:0] stack [STACK_DEPTH];

    logic busy;
    logic is_call;
    logic is_clear_file_reg;
    logic is_complement_file_reg;
    logic is_clear_watchdog;
    logic [7:0] mem_rd;
    logic [7:0] mem_win;
    logic [20:0] return_stack_top;
    logic [20:0] pc_ret;
    logic core_we;
    logic [7:0] core_wdata;
    logic axi_mem_we;
    logic [7:0] axi_mem_data;
    logic push;
    logic wdt_clr;
    logic wdt_timeout;
    logic [WDT_CNT_W-1:0] wdt_count;
    logic [WDT_POST_W-1:0] wdt_post;
    logic [31:0] wv;
    logic [31:0] msk;
    logic [31:0] rv;

    function automatic logic [ADDR_W-1:0] eff_addr(
        input logic [15:0] ir,
        input logic [BSR_W-1:0] bank_select_reg,
        input logic ext,
        input logic [ADDR_W-1:0] fsr2
    );
        logic [7:0] f;
        f = ir[7:0];
        if (!ir[8] && ext && f <= ILO_LIMIT)
            eff_addr = ADDR_W'(fsr2 + {{BSR_W{1'b0}}, f});
        else if (!ir[8])
            eff_addr = (f <= ILO_LIMIT) ? {{BSR_W{1'b0}}, f}
                                        : {{BSR_W{1'b1}}, f};
        else
            eff_addr = {bank_select_reg, f};
    endfunction

    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] strb
    );
        merge = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                merge[8*i +: 8] = nw[8*i +: 8];
    endfunction

    assign busy = state_ff.st != S_IDLE;
    assign is_call = state_ff.ir == OP_CALL_W;
    assign is_clear_watchdog = state_ff.ir == OP_CLR_WDT;
    assign is_clear_file_reg = state_ff.ir[15:9] == OP_CLEAR_FILE_REG_HI;
    assign is_complement_file_reg = state_ff.ir[15:10] == OP_COMPLEMENT_FILE_REG_HI;
    assign mem_rd = mem[state_ff.ea];
    assign mem_win = mem[state_ff.mem_addr];
    assign return_stack_top = (state_ff.sp == '0) ? '0 : stack[state_ff.sp - 1'b1];
    assign pc_ret = state_ff.pc + PC_STEP;
    assign wdt_clr = ce && state_ff.st == S_EXEC && state_ff.q == Q_PROC
        && is_clear_watchdog;

    watchdog_counter #(
        .CNT_W(WDT_CNT_W),
        .POST_W(WDT_POST_W)
    ) u_wdt (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .clr(wdt_clr),
        .count(wdt_count),
        .post(wdt_post),
        .timeout(wdt_timeout)
    );

    always_comb
    begin
        nxt_state = state_ff;
        core_we = 1'b0;
        core_wdata = '0;
        axi_mem_we = 1'b0;
        axi_mem_data = '0;
        push = 1'b0;
        wv = merge('0, state_ff.wdata, state_ff.wstrb);
        // Byte mask keeps unstrobed bytes of wide registers
        msk = merge('0, 32'hffffffff, state_ff.wstrb);
        rv = '0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            nxt_state.aw_got = 1'b1;
            nxt_state.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            nxt_state.w_got = 1'b1;
            nxt_state.wdata = s_axi_wdata;
            nxt_state.wstrb = s_axi_wstrb;
        end
        if (state_ff.bvalid && s_axi_bready)
            nxt_state.bvalid = 1'b0;
        // Writes arriving mid-instruction are answered but dropped
        if (state_ff.aw_got && state_ff.w_got && !state_ff.bvalid)
        begin
            nxt_state.aw_got = 1'b0;
            nxt_state.w_got = 1'b0;
            nxt_state.bvalid = 1'b1;
            nxt_state.bresp = RESP_OKAY;
            case (state_ff.awaddr)
                REG_CTRL:
                    if (!busy && state_ff.wstrb[0])
                    begin
                        nxt_state.ext = wv[CTRL_EXT];
                        if (wv[CTRL_GO])
                        begin
                            nxt_state.st = S_EXEC;
                            nxt_state.q = Q_DECODE;
                        end
                    end
                REG_INSTR:
                    if (!busy)
                        nxt_state.ir = wv[15:0] | (state_ff.ir & ~msk[15:0]);
                REG_WREG:
                    if (!busy && state_ff.wstrb[0])
                        nxt_state.wreg = wv[7:0];
                REG_BSR:
                    if (!busy && state_ff.wstrb[0])
                        nxt_state.bank_select_reg = wv[BSR_W-1:0];
                REG_PC:
                    if (!busy)
                        nxt_state.pc = wv[20:0] | (state_ff.pc & ~msk[20:0]);
                REG_PC_HIGH_LATCH:
                    if (!busy && state_ff.wstrb[0])
                        nxt_state.pc_high_latch = wv[7:0];
                REG_PC_UPPER_LATCH:
                    if (!busy && state_ff.wstrb[0])
                        nxt_state.pc_upper_latch = wv[4:0];
                REG_STATUS:
                    if (!busy && state_ff.wstrb[0])
                    begin
                        nxt_state.n = wv[ST_N];
                        nxt_state.z = wv[ST_Z];
                        nxt_state.bad = state_ff.bad & ~wv[ST_BAD];
                        nxt_state.ovf = state_ff.ovf & ~wv[ST_OVF];
                    end
                REG_FSR2:
                    if (!busy)
                        nxt_state.fsr2 = wv[ADDR_W-1:0]
                            | (state_ff.fsr2 & ~msk[ADDR_W-1:0]);
                REG_MEM_ADDR:
                    if (!busy)
                        nxt_state.mem_addr = wv[ADDR_W-1:0]
                            | (state_ff.mem_addr & ~msk[ADDR_W-1:0]);
                REG_MEM_DATA:
                begin
                    axi_mem_we = !busy && state_ff.wstrb[0];
                    axi_mem_data = wv[7:0];
                end
                REG_TOS, REG_WDT:
                    nxt_state.bresp = RESP_OKAY;
                default:
                    nxt_state.bresp = RESP_SLVERR;
            endcase
        end
        if (state_ff.rvalid && s_axi_rready)
            nxt_state.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp = RESP_OKAY;
            case (s_axi_araddr)
                REG_CTRL: rv[CTRL_EXT] = state_ff.ext;
                REG_INSTR: rv = 32'(state_ff.ir);
                REG_WREG: rv = 32'(state_ff.wreg);
                REG_BSR: rv = 32'(state_ff.bank_select_reg);
                REG_PC: rv = 32'(state_ff.pc);
                REG_PC_HIGH_LATCH: rv = 32'(state_ff.pc_high_latch);
                REG_PC_UPPER_LATCH: rv = 32'(state_ff.pc_upper_latch);
                REG_STATUS:
                begin
                    rv[ST_BUSY] = busy;
                    rv[ST_N] = state_ff.n;
                    rv[ST_Z] = state_ff.z;
                    rv[ST_TO] = state_ff.to_flag;
                    rv[ST_PD] = state_ff.pd_flag;
                    rv[ST_BAD] = state_ff.bad;
                    rv[ST_OVF] = state_ff.ovf;
                end
                REG_TOS:
                begin
                    rv = 32'(return_stack_top);
                    rv[TOS_SP_LSB +: SP_W] = state_ff.sp;
                end
                REG_WDT: rv = 32'({wdt_post, wdt_count});
                REG_FSR2: rv = 32'(state_ff.fsr2);
                REG_MEM_ADDR: rv = 32'(state_ff.mem_addr);
                REG_MEM_DATA: rv = 32'(mem_win);
                default: nxt_state.rresp = RESP_SLVERR;
            endcase
            nxt_state.rdata = rv;
        end
        unique case (state_ff.st)
            S_IDLE:
                nxt_state.q = state_ff.q;
            S_EXEC:
            begin
                nxt_state.q = state_ff.q + 2'h1;
                unique case (state_ff.q)
                    Q_DECODE:
                    begin
                        nxt_state.ea = eff_addr(state_ff.ir, state_ff.bank_select_reg,
                            state_ff.ext, state_ff.fsr2);
                        if (!(is_call || is_clear_file_reg || is_complement_file_reg || is_clear_watchdog))
                            nxt_state.bad = 1'b1;
                    end
                    Q_READ:
                        nxt_state.opnd = mem_rd;
                    Q_PROC:
                    begin
                        nxt_state.res = is_complement_file_reg ? ~state_ff.opnd : 8'h00;
                        if (is_call)
                        begin
                            // A full stack drops the return address and flags it
                            if (state_ff.sp < SP_W'(STACK_DEPTH))
                            begin
                                push = 1'b1;
                                nxt_state.sp = state_ff.sp + 1'b1;
                            end
                            else
                                nxt_state.ovf = 1'b1;
                        end
                        if (is_clear_watchdog)
                        begin
                            nxt_state.to_flag = 1'b1;
                            nxt_state.pd_flag = 1'b1;
                        end
                    end
                    Q_WRITE:
                    begin
                        if (is_clear_file_reg)
                        begin
                            core_we = 1'b1;
                            nxt_state.z = 1'b1;
                        end
                        if (is_complement_file_reg)
                        begin
                            nxt_state.n = state_ff.res[7];
                            nxt_state.z = state_ff.res == 8'h00;
                            if (state_ff.ir[9])
                            begin
                                core_we = 1'b1;
                                core_wdata = state_ff.res;
                            end
                            else
                                nxt_state.wreg = state_ff.res;
                        end
                        if (is_call)
                        begin
                            nxt_state.pc = {state_ff.pc_upper_latch, state_ff.pc_high_latch,
                                state_ff.wreg};
                            nxt_state.st = S_NOP;
                        end
                        else
                        begin
                            nxt_state.pc = pc_ret;
                            nxt_state.st = S_IDLE;
                        end
                    end
                endcase
            end
            S_NOP:
            begin
                nxt_state.q = state_ff.q + 2'h1;
                if (state_ff.q == Q_WRITE)
                    nxt_state.st = S_IDLE;
            end
        endcase
        // Expiry is the later event and must not be lost under a clear
        if (wdt_timeout)
            nxt_state.to_flag = 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_ff <= '0;
            state_ff.st <= S_IDLE;
            state_ff.to_flag <= TO_RST;
            state_ff.pd_flag <= PD_RST;
        end
        else if (ce)
            state_ff <= nxt_state;
    end

    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (core_we)
                mem[state_ff.ea] <= core_wdata;
            else if (axi_mem_we)
                mem[state_ff.mem_addr] <= axi_mem_data;
            if (push)
                stack[state_ff.sp] <= pc_ret;
        end
    end

    assign s_axi_awready = ce && !state_ff.aw_got && !state_ff.bvalid;
    assign s_axi_wready = ce && !state_ff.w_got && !state_ff.bvalid;
    assign s_axi_bvalid = state_ff.bvalid;
    assign s_axi_bresp = state_ff.bresp;
    assign s_axi_arready = ce && !state_ff.rvalid;
    assign s_axi_rvalid = state_ff.rvalid;
    assign s_axi_rresp = state_ff.rresp;
    assign s_axi_rdata = state_ff.rdata;

    logic exq;
    assign exq = ce && state_ff.st == S_EXEC;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    call_push_a: assert property (exq && state_ff.q == Q_WRITE && is_call
        && !state_ff.ovf |=> return_stack_top == $past(pc_ret))
        else $error("call did not push return address");
    call_decode_a: assert property (exq && state_ff.q == Q_WRITE
        && state_ff.ir == 16'h0014 |=> state_ff.st == S_NOP)
        else $error("call pattern not decoded");
    pc_low_a: assert property (exq && state_ff.q == Q_WRITE && is_call
        |=> state_ff.pc[7:0] == $past(state_ff.wreg))
        else $error("pc low byte not loaded from accumulator");
    pc_latch_a: assert property (exq && state_ff.q == Q_WRITE && is_call
        |=> state_ff.pc[20:8] == {$past(state_ff.pc_upper_latch),
            $past(state_ff.pc_high_latch)})
        else $error("pc high bytes not loaded from latches");
    call_nop_a: assert property (ce && state_ff.st == S_NOP
        && state_ff.q == Q_WRITE |=> state_ff.st == S_IDLE
        && $stable(state_ff.pc))
        else $error("second call cycle not a plain nop");
    call_flags_a: assert property (exq && is_call |=> $stable(state_ff.n)
        && $stable(state_ff.z) && $stable(state_ff.pd_flag)
        && $stable(state_ff.bank_select_reg))
        else $error("call changed flags or bank select");
    clear_file_reg_zero_a: assert property (exq && state_ff.q == Q_WRITE && is_clear_file_reg
        |=> state_ff.z && mem_rd == 8'h00)
        else $error("clear register failed");
    bank_sel_a: assert property (exq && state_ff.q == Q_DECODE
        && state_ff.ir[8] |=> state_ff.ea == {$past(state_ff.bank_select_reg),
            $past(state_ff.ir[7:0])})
        else $error("banked address wrong");
    indexed_a: assert property (exq && state_ff.q == Q_DECODE
        && !state_ff.ir[8] && state_ff.ext && state_ff.ir[7:0] <= 8'h5f
        |=> state_ff.ea == ADDR_W'($past(state_ff.fsr2)
            + $past(state_ff.ir[7:0])))
        else $error("indexed literal offset address wrong");
    wdt_clear_a: assert property (wdt_clr |=> wdt_count == '0
        && wdt_post == '0 && state_ff.to_flag && state_ff.pd_flag)
        else $error("clear watchdog incomplete");
    complement_file_reg_w_a: assert property (exq && state_ff.q == Q_WRITE && is_complement_file_reg
        && !state_ff.ir[9] |=> state_ff.wreg == ~$past(state_ff.opnd))
        else $error("complement to accumulator wrong");
    complement_file_reg_f_a: assert property (exq && state_ff.q == Q_WRITE && is_complement_file_reg
        && state_ff.ir[9] |=> mem_rd == ~$past(state_ff.opnd)
            && $stable(state_ff.wreg))
        else $error("complement write back wrong");
    complement_file_reg_flags_a: assert property (exq && state_ff.q == Q_WRITE && is_complement_file_reg
        |=> state_ff.n == $past(state_ff.res[7])
            && $stable(state_ff.pd_flag))
        else $error("complement flags wrong");
    quarter_a: assert property (exq && state_ff.q == Q_DECODE
        && !is_call |=> state_ff.q == Q_READ ##1 state_ff.q == Q_PROC
            ##1 state_ff.q == Q_WRITE)
        else $error("quarter sequence broken");
    call_keep_a: assert property (exq && state_ff.q == Q_WRITE && is_call
        |=> $stable(state_ff.pc_high_latch) && $stable(state_ff.pc_upper_latch)
            && $stable(state_ff.wreg))
        else $error("call disturbed latches or accumulator");

    call_c: cover property (exq && state_ff.q == Q_WRITE && is_call);
    clear_file_reg_c: cover property (exq && state_ff.q == Q_WRITE && is_clear_file_reg);
    complement_file_reg_c: cover property (exq && state_ff.q == Q_WRITE && is_complement_file_reg);
    wdt_c: cover property (wdt_clr);
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the instruction execution block.
// Assumes an AXI4-Lite master on a 50 MHz clk with ce held high.
`timescale 1ns/1ps
module tb;
    import exec_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    call_clear_complement_exec dut_u (.clk(clk), .srst(srst), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    initial forever #10 clk = ~clk;
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Handshakes are sampled at the falling edge, so the rising edge that
    // follows is the one at which the item moves.
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_hs, w_hs, b_hs;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_hs = 1'b0;
        while (!b_hs)
        begin
            @(negedge clk);
            aw_hs = awvalid & awready;
            w_hs = wvalid & wready;
            b_hs = bvalid & bready;
            @(posedge clk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task rdr(input logic [7:0] a);
        logic ar_hs, r_hs;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_hs = 1'b0;
        while (!r_hs)
        begin
            @(negedge clk);
            ar_hs = arvalid & arready;
            r_hs = rvalid & rready;
            rd = rdata;
            rsp = rresp;
            @(posedge clk);
            if (ar_hs) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task run(input logic [15:0] op, input logic ext);
        wr(REG_INSTR, {16'h0, op});
        wr(REG_CTRL, {30'h0, ext, 1'b1});
        repeat (4) @(posedge clk);
        rdr(REG_STATUS);
        if (op === OP_CALL_W) check({31'h0, rd[ST_BUSY]}, 32'h1);
        while (rd[ST_BUSY] !== 1'b0) rdr(REG_STATUS);
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // A hang anywhere is caught here rather than by each wait loop
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            tally_and_finish;
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        wr(REG_PC, 32'h100);
        wr(REG_PC_HIGH_LATCH, 32'h10);
        wr(REG_PC_UPPER_LATCH, 32'h0);
        wr(REG_WREG, 32'h06);
        wr(REG_STATUS, 32'h6);
        run(OP_CALL_W, 1'b0);
        rdr(REG_PC);
        check(rd, 32'h001006);
        rdr(REG_TOS);
        check(rd, 32'h01000102);
        rdr(REG_WREG);
        check(rd, 32'h06);
        rdr(REG_PC_HIGH_LATCH);
        check(rd, 32'h10);
        rdr(REG_STATUS);
        check({28'h0, rd[6:5], rd[2:1]}, 32'h3);
        $display("test call done");
        wr(REG_BSR, 32'h2);
        wr(REG_MEM_ADDR, 32'h240);
        wr(REG_MEM_DATA, 32'h5a);
        wr(REG_STATUS, 32'h0);
        run(16'h6b40, 1'b0);
        rdr(REG_MEM_DATA);
        check(rd, 32'h0);
        rdr(REG_STATUS);
        check({31'h0, rd[ST_Z]}, 32'h1);
        wr(REG_MEM_ADDR, 32'h020);
        wr(REG_MEM_DATA, 32'h77);
        run(16'h6a20, 1'b0);
        rdr(REG_MEM_DATA);
        check(rd, 32'h0);
        $display("test clear done");
        wr(REG_FSR2, 32'h300);
        wr(REG_MEM_ADDR, 32'h310);
        wr(REG_MEM_DATA, 32'h13);
        run(16'h1c10, 1'b1);
        rdr(REG_WREG);
        check(rd, 32'hec);
        rdr(REG_MEM_DATA);
        check(rd, 32'h13);
        rdr(REG_STATUS);
        check({30'h0, rd[2:1]}, 32'h1);
        wr(REG_MEM_DATA, 32'hff);
        run(16'h1e10, 1'b1);
        rdr(REG_MEM_DATA);
        check(rd, 32'h0);
        rdr(REG_STATUS);
        check({30'h0, rd[2:1]}, 32'h2);
        $display("test complement done");
        // Long idle lets the default-size watchdog expire first
        repeat (20000) @(posedge clk);
        rdr(REG_STATUS);
        check({31'h0, rd[ST_TO]}, 32'h0);
        run(OP_CLR_WDT, 1'b0);
        rdr(REG_STATUS);
        check({30'h0, rd[ST_TO], rd[ST_PD]}, 32'h3);
        rdr(REG_WDT);
        check({28'h0, rd[11:8]}, 32'h0);
        rdr(8'h3c);
        check({30'h0, rsp}, {30'h0, RESP_SLVERR});
        $display("test watchdog done");
        tally_and_finish;
    end
endmodule
